// ---- tsc_pkg.sv ----
// Package with register layout and constants for the trigger sequencer control block
`default_nettype none
package tsc_pkg;
  localparam logic [3:0] CSR_ADDR = 4'h0;
  localparam logic [3:0] IRQ_STAT_ADDR = 4'h1;
  localparam logic [3:0] IRQ_MASK_ADDR = 4'h2;
  localparam logic [3:0] SD_LIM_ADDR = 4'h3;
  localparam logic [3:0] LC_LIM_ADDR = 4'h4;
  localparam logic [3:0] IT_LIM_ADDR = 4'h5;
  localparam logic [3:0] CMD_ADDR = 4'h6;
  localparam int BIT_ENABLE = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int BIT_TOGGLE = 12;
  localparam int BIT_SOFT_TRIG = 10;
  localparam int BIT_SINGLE_STEP = 9;
  localparam int BIT_VISIBILITY = 8;
  localparam int BIT_RUN = 7;
  localparam int BIT_WDT_FLAG = 6;
  localparam int BIT_WAIT_HI = 1;
  localparam int BIT_WAIT_LO = 0;
  localparam logic [15:0] CSR_WRITE_MASK = 16'hB783;
  localparam logic [15:0] CSR_RESET = 16'h0000;
  localparam logic [15:0] LIM_RESET = 16'h0000;
  localparam logic [15:0] WDT_LIMIT = 16'h00FF;
  localparam logic [7:0] PULSE_RESET = 8'h01;
  localparam int IRQ_WDT = 0;
  localparam int IRQ_TRIG = 1;
  localparam int IRQ_STEP = 2;
  // Command opcodes written to the command register, bits 15:12
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_TRIG = 4'h1;
  localparam logic [3:0] OP_WAIT_HI = 4'h2;
  localparam logic [3:0] OP_WAIT_LO = 4'h3;
  localparam logic [3:0] OP_CTRL_SWT = 4'h4;
  localparam logic [3:0] OP_DELAY = 4'h5;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_EXEC = 4'b0100,
    ST_HOLD = 4'b1000
  } tsc_state_type;
endpackage : tsc_pkg
`default_nettype wire

// ---- tsc_top.sv ----
// Trigger sequencer control/status register bank with a small step executor
// Function
// (R1) Enable bit 15 turns the sequencer on; clear holds it disabled.
// (R2) Idle-stop bit 13 set halts the sequencer during device Idle mode.
// (R3) Toggle mode bit 12 set: each emit-trigger inverts the trigger output.
// (R4) Toggle mode clear: each emit-trigger gives one pulse of set width.
// (R5) Writing one to soft-trigger bit 10 triggers; writing zero does nothing.
// (R6) Soft-trigger bit is consulted only by the control step command; the code also uses it to release a single-step hold.
// (R7) Single-step bit 9 enters single-step mode; for debugging tools only.
// (R8) Visibility bit 8 set: limit register reads return live counters.
// (R9) Visibility clear: limit register reads return last written values.
// (R10) Run bit 7 starts continuous command execution; clear stops it.
// (R11) Hardware sets watchdog timeout flag bit 6; software cannot set it.
// (R12) Wait-input mode bits 1:0 affect only wait-high and wait-low commands.
// (R13) Bits 14, 11 and 5 to 2 ignore writes and read zero.
// (R14) All implemented control/status bits clear to zero at reset.
`timescale 1ns/1ps
`default_nettype none
module tsc_top #(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  // Device state and wait input pin
  input wire logic idle_mode_in,
  input wire logic wait_pin_in,
  // Trigger output and interrupt
  output logic trigger_output_out,
  output logic irq_out
);
  localparam int AW = $clog2(DEPTH);
  // Pointers wrap by overflow, so the depth must be a power of two
  if (DEPTH < 2 || DEPTH > 256 || (1 << AW) != DEPTH) begin : g_depth_bad
    $error("DEPTH out of range");
  end

  logic [15:0] csr_q, csr_d, stat_q, stat_d, mask_q, mask_d;
  logic [15:0] sdlim_q, sdlim_d, lclim_q, lclim_d, itlim_q, itlim_d;
  logic [15:0] sd_cnt_q, sd_cnt_d, lc_cnt_q, lc_cnt_d, it_cnt_q, it_cnt_d;
  logic [15:0] wdt_q, wdt_d, rdata_q, rdata_d;
  logic [15:0] prog_q [DEPTH];
  logic [AW-1:0] wptr_q, wptr_d, pc_q, pc_d;
  logic [7:0] pulse_q, pulse_d;
  logic [15:0] cmd_q, cmd_d;
  logic swt_q, swt_d, trig_q, trig_d, irq_q, irq_d;
  logic pin_m_q, pin_s_q, idle_m_q, idle_s_q, wdt_ev, trig_ev, step_ev;
  tsc_pkg::tsc_state_type st_q, st_d;

  function automatic logic csr_write(input logic [3:0] a, input logic w);
    return w && (a == tsc_pkg::CSR_ADDR);
  endfunction

  function automatic logic wait_done(input logic [1:0] mode, input logic hi, input logic pin);
    logic lvl;
    lvl = mode[tsc_pkg::BIT_WAIT_LO] ? ~pin : pin;
    return hi ? lvl : ~lvl;
  endfunction

  logic wr_csr, running, done;
  always_comb begin
    wr_csr = csr_write(reg_addr_in, reg_wr_in);
    // (R1) Enable gates all
    // (R2) Idle stop halt
    running = csr_q[tsc_pkg::BIT_ENABLE] &&
              !(csr_q[tsc_pkg::BIT_IDLE_STOP] && idle_s_q);
  end

  // Sequencer and register next state
  always_comb begin
    csr_d = csr_q;
    stat_d = stat_q;
    mask_d = mask_q;
    sdlim_d = sdlim_q;
    lclim_d = lclim_q;
    itlim_d = itlim_q;
    sd_cnt_d = sd_cnt_q;
    lc_cnt_d = lc_cnt_q;
    it_cnt_d = it_cnt_q;
    wdt_d = wdt_q;
    wptr_d = wptr_q;
    pc_d = pc_q;
    pulse_d = pulse_q;
    cmd_d = cmd_q;
    swt_d = swt_q;
    trig_d = trig_q;
    st_d = st_q;
    wdt_ev = 1'b0;
    trig_ev = 1'b0;
    step_ev = 1'b0;
    done = 1'b1;
    if (wr_csr) begin
      // (R13) Unimplemented bits dropped
      csr_d = (reg_wdata_in & tsc_pkg::CSR_WRITE_MASK) |
              (csr_q & ~tsc_pkg::CSR_WRITE_MASK);
      csr_d[tsc_pkg::BIT_SOFT_TRIG] = 1'b0;
    end
    if (reg_wr_in) begin
      case (reg_addr_in)
        tsc_pkg::SD_LIM_ADDR: sdlim_d = reg_wdata_in;
        tsc_pkg::LC_LIM_ADDR: lclim_d = reg_wdata_in;
        tsc_pkg::IT_LIM_ADDR: begin
          itlim_d = reg_wdata_in;
          pulse_d = (reg_wdata_in[15:8] == 8'h00) ? tsc_pkg::PULSE_RESET : reg_wdata_in[15:8];
        end
        tsc_pkg::CMD_ADDR: wptr_d = wptr_q + 1'b1;
        tsc_pkg::IRQ_MASK_ADDR: mask_d = reg_wdata_in;
        tsc_pkg::IRQ_STAT_ADDR: stat_d = stat_q & ~reg_wdata_in;
        default: begin
        end
      endcase
    end
    // Pulse countdown; in toggle mode the level is left alone
    if (!csr_q[tsc_pkg::BIT_TOGGLE] && trig_q && it_cnt_q != 16'h0000) begin
      it_cnt_d = it_cnt_q - 16'h0001;
    end else if (!csr_q[tsc_pkg::BIT_TOGGLE] && trig_q) begin
      trig_d = 1'b0;
    end
    case (st_q)
      tsc_pkg::ST_IDLE: begin
        pc_d = '0;
        wdt_d = '0;
        // (R10) Run starts execution
        if (running && csr_q[tsc_pkg::BIT_RUN]) begin
          st_d = tsc_pkg::ST_FETCH;
        end
      end
      tsc_pkg::ST_FETCH: begin
        cmd_d = prog_q[pc_q];
        wdt_d = '0;
        sd_cnt_d = sdlim_q;
        st_d = tsc_pkg::ST_EXEC;
      end
      tsc_pkg::ST_EXEC: begin
        case (cmd_q[15:12])
          tsc_pkg::OP_TRIG: begin
            trig_ev = 1'b1;
            // (R3) Toggle mode invert
            if (csr_q[tsc_pkg::BIT_TOGGLE]) begin
              trig_d = ~trig_q;
            // (R4) Single width pulse
            end else begin
              trig_d = 1'b1;
              it_cnt_d = {8'h00, pulse_q} - 16'h0001;
            end
          end
          // (R12) Wait mode bits here only
          tsc_pkg::OP_WAIT_HI: begin
            done = wait_done(csr_q[1:0], 1'b1, pin_s_q);
          end
          tsc_pkg::OP_WAIT_LO: begin
            done = wait_done(csr_q[1:0], 1'b0, pin_s_q);
          end
          // (R6) Soft trigger consulted
          tsc_pkg::OP_CTRL_SWT: begin
            done = swt_q;
            if (swt_q) begin
              swt_d = 1'b0;
            end
          end
          tsc_pkg::OP_DELAY: begin
            done = (sd_cnt_q == 16'h0000);
            if (!done) begin
              sd_cnt_d = sd_cnt_q - 16'h0001;
            end
          end
          default: begin
            lc_cnt_d = lc_cnt_q + 16'h0001;
          end
        endcase
        if (!done) begin
          wdt_d = wdt_q + 16'h0001;
        end
        // (R11) Watchdog expiry flags
        if (!done && wdt_q == tsc_pkg::WDT_LIMIT) begin
          wdt_ev = 1'b1;
          csr_d[tsc_pkg::BIT_WDT_FLAG] = 1'b1;
          csr_d[tsc_pkg::BIT_RUN] = 1'b0;
          st_d = tsc_pkg::ST_IDLE;
        end else if (done) begin
          pc_d = pc_q + 1'b1;
          step_ev = 1'b1;
          // (R7) Single step pauses
          st_d = csr_q[tsc_pkg::BIT_SINGLE_STEP] ? tsc_pkg::ST_HOLD : tsc_pkg::ST_FETCH;
        end
      end
      tsc_pkg::ST_HOLD: begin
        if (!csr_q[tsc_pkg::BIT_SINGLE_STEP] || swt_q) begin
          swt_d = 1'b0;
          st_d = tsc_pkg::ST_FETCH;
        end
      end
      default: begin
        st_d = tsc_pkg::ST_IDLE;
      end
    endcase
    // (R5) Soft trigger on one; a fresh write wins over consumption
    if (wr_csr && reg_wdata_in[tsc_pkg::BIT_SOFT_TRIG]) begin
      swt_d = 1'b1;
    end
    // (R10) Clearing run stops
    if (!running || !csr_q[tsc_pkg::BIT_RUN]) begin
      st_d = tsc_pkg::ST_IDLE;
    end
    // (R1) Disabled clears output
    if (!csr_q[tsc_pkg::BIT_ENABLE]) begin
      trig_d = 1'b0;
    end
    // Set wins over write-one clear
    if (wdt_ev) begin
      stat_d[tsc_pkg::IRQ_WDT] = 1'b1;
    end
    if (trig_ev) begin
      stat_d[tsc_pkg::IRQ_TRIG] = 1'b1;
    end
    if (step_ev) begin
      stat_d[tsc_pkg::IRQ_STEP] = 1'b1;
    end
    irq_d = |(stat_d & mask_d);
  end

  // Read path
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        tsc_pkg::CSR_ADDR: rdata_d = csr_q & tsc_pkg::CSR_WRITE_MASK | (csr_q & 16'h0040);
        tsc_pkg::IRQ_STAT_ADDR: rdata_d = stat_q;
        tsc_pkg::IRQ_MASK_ADDR: rdata_d = mask_q;
        // (R8) Live counters visible
        // (R9) Otherwise written limits
        tsc_pkg::SD_LIM_ADDR: rdata_d = csr_q[tsc_pkg::BIT_VISIBILITY] ? sd_cnt_q : sdlim_q;
        tsc_pkg::LC_LIM_ADDR: rdata_d = csr_q[tsc_pkg::BIT_VISIBILITY] ? lc_cnt_q : lclim_q;
        tsc_pkg::IT_LIM_ADDR: rdata_d = csr_q[tsc_pkg::BIT_VISIBILITY] ? it_cnt_q : itlim_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reg_wr_in && reg_addr_in == tsc_pkg::CMD_ADDR) begin
      prog_q[wptr_q] <= reg_wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    pin_m_q <= wait_pin_in;
    pin_s_q <= pin_m_q;
    idle_m_q <= idle_mode_in;
    idle_s_q <= idle_m_q;
    // (R14) Reset clears all state here except pulse_q (loads PULSE_RESET), st_q (loads ST_IDLE) and the input synchronizers
    if (!rst_n_in) begin
      csr_q <= tsc_pkg::CSR_RESET;
      stat_q <= '0;
      mask_q <= '0;
      sdlim_q <= tsc_pkg::LIM_RESET;
      lclim_q <= tsc_pkg::LIM_RESET;
      itlim_q <= tsc_pkg::LIM_RESET;
      sd_cnt_q <= '0;
      lc_cnt_q <= '0;
      it_cnt_q <= '0;
      wdt_q <= '0;
      wptr_q <= '0;
      pc_q <= '0;
      pulse_q <= tsc_pkg::PULSE_RESET;
      cmd_q <= '0;
      swt_q <= 1'b0;
      trig_q <= 1'b0;
      irq_q <= 1'b0;
      rdata_q <= '0;
      st_q <= tsc_pkg::ST_IDLE;
    end else begin
      csr_q <= csr_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      sdlim_q <= sdlim_d;
      lclim_q <= lclim_d;
      itlim_q <= itlim_d;
      sd_cnt_q <= sd_cnt_d;
      lc_cnt_q <= lc_cnt_d;
      it_cnt_q <= it_cnt_d;
      wdt_q <= wdt_d;
      wptr_q <= wptr_d;
      pc_q <= pc_d;
      pulse_q <= pulse_d;
      cmd_q <= cmd_d;
      swt_q <= swt_d;
      trig_q <= trig_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
      st_q <= st_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign trigger_output_out = trig_q;
  assign irq_out = irq_q;

  // (R13) Reserved bits zero
  chk_reserved_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // (R13)
    (csr_q & 16'h483C) == 16'h0000) else $error("reserved bit set");
  // (R11) Flag only by hardware
  chk_wdt_flag_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // (R11)
    $rose(csr_q[6]) |-> $past(wdt_ev)) else $error("timeout flag set by write");
  // (R1) Disabled means idle
  chk_disable_idle: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // (R1)
    !csr_q[15] |=> st_q == tsc_pkg::ST_IDLE) else $error("runs while disabled");
  // (R3) Toggle inverts output
  chk_toggle_flip: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // (R3)
    trig_ev && csr_q[12] && csr_q[15] |=> trig_q != $past(trig_q)) else $error("no toggle");
  // (R4) Pulse ends in time
  chk_pulse_end: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // (R4)
    $rose(trig_q) && !csr_q[12] && !wr_csr |-> ##[1:260] !trig_q) else $error("pulse stuck");
  // (R8) Visible live counter
  chk_vis_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // (R8)
    reg_rd_in && reg_addr_in == tsc_pkg::SD_LIM_ADDR && csr_q[8]
    |=> reg_rdata_out == $past(sd_cnt_q)) else $error("live read wrong");
  // (R9) Written limit read
  chk_lim_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // (R9)
    reg_rd_in && reg_addr_in == tsc_pkg::LC_LIM_ADDR && !csr_q[8]
    |=> reg_rdata_out == $past(lclim_q)) else $error("limit read wrong");
  // (R10) Clear run stops
  chk_run_stop: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // (R10)
    !csr_q[7] |=> st_q == tsc_pkg::ST_IDLE) else $error("runs after stop");
  // (R5) Soft trigger latched
  chk_soft_trig: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // (R5)
    wr_csr && reg_wdata_in[10] |=> swt_q) else $error("soft trigger lost");
  cov_toggle: cover property (@(posedge sys_clk_in) trig_ev && csr_q[12]);
  cov_pulse: cover property (@(posedge sys_clk_in) trig_ev && !csr_q[12]);
  cov_wdt: cover property (@(posedge sys_clk_in) wdt_ev);
  cov_step_hold: cover property (@(posedge sys_clk_in) st_q == tsc_pkg::ST_HOLD);
endmodule // tsc_top
`default_nettype wire

// ---- tsc_trig_sink.sv ----
// Peripheral model on the trigger output side, also driving the wait input pin
`timescale 1ns/1ps
`default_nettype none
module tsc_trig_sink (
  // Clock
  input wire logic sys_clk_in,
  // Trigger from the sequencer and the level the peripheral presents
  input wire logic trigger_output_in,
  input wire logic wait_level_in,
  // Wait pin and measured pulse data
  output logic wait_pin_out,
  output logic [15:0] last_width_out,
  output logic [15:0] edge_count_out
);
  logic [15:0] run_q = 16'h0000;
  logic prev_q = 1'b0;
  // Peripheral holds its status line steady; the pin is sampled async by the block
  assign wait_pin_out = wait_level_in;
  initial last_width_out = 16'h0000;
  initial edge_count_out = 16'h0000;
  always @(posedge sys_clk_in) begin
    prev_q <= trigger_output_in;
    if (trigger_output_in !== prev_q) edge_count_out <= edge_count_out + 16'h0001;
    if (trigger_output_in === 1'b1) run_q <= run_q + 16'h0001;
    else if (run_q != 16'h0000) begin
      last_width_out <= run_q;
      run_q <= 16'h0000;
    end
  end
endmodule // tsc_trig_sink
`default_nettype wire

// ---- tsc_tb.sv ----
// Self-checking testbench for the trigger sequencer control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic idle = 1'b0;
  logic wait_level = 1'b0;
  logic rd_late = 1'b0;
  logic [15:0] rdata;
  logic trig;
  logic irq;
  logic wait_pin;
  logic [15:0] width;
  logic [15:0] edges;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'd62328;
  logic [15:0] v;
  int fails = 0;
  int total_checks = 0;

  always #5 sys_clk = ~sys_clk;

  tsc_top #(.DEPTH(8)) dut_u (
    .sys_clk_in(sys_clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .idle_mode_in(idle),
    .wait_pin_in(wait_pin), .trigger_output_out(trig), .irq_out(irq)
  );

  tsc_trig_sink sink_u (
    .sys_clk_in(sys_clk), .trigger_output_in(trig), .wait_level_in(wait_level),
    .wait_pin_out(wait_pin), .last_width_out(width), .edge_count_out(edges)
  );

  function automatic logic [15:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // Read data are checked by the watcher one cycle later
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(exp);
    @(posedge sys_clk);
    rd <= 1'b0;
  endtask

  // Bounded watch of the trigger line
  task automatic see_trig(input logic want, input int n);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < n && !(want && seen); i++) begin
      @(negedge sys_clk);
      if (trig === 1'b1) seen = 1'b1;
    end
    chk("trigger", {15'h0000, want}, {15'h0000, seen});
    // Hand back on a rising edge so the next drive lands there
    @(posedge sys_clk);
  endtask

  task automatic see_irq(input logic want);
    repeat (3) @(negedge sys_clk);
    chk("irq", {15'h0000, want}, {15'h0000, irq});
  endtask

  always @(posedge sys_clk) rd_late <= rd;

  // Watcher: read data stand only in the cycle after the strobe
  always @(negedge sys_clk) begin
    if (rd_late) begin
      if (exp_q.size() == 0) chk("queue", 16'h0001, 16'h0000);
      else chk("read data", exp_q.pop_front(), rdata);
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_reg(tsc_pkg::CSR_ADDR, tsc_pkg::CSR_RESET);
    rd_reg(tsc_pkg::IRQ_STAT_ADDR, 16'h0000);
    wr_reg(tsc_pkg::CSR_ADDR, 16'h4C7C);
    rd_reg(tsc_pkg::CSR_ADDR, 16'h0000);
    rd_reg(4'hF, 16'h0000);
    // Random control writes with the sequencer kept off
    for (int i = 0; i < 8; i++) begin
      v = next_rand() & 16'h7F7F;
      wr_reg(tsc_pkg::CSR_ADDR, v);
      rd_reg(tsc_pkg::CSR_ADDR, v & 16'h3303);
    end
    wr_reg(tsc_pkg::CSR_ADDR, 16'h0000);
    for (int a = 3; a < 6; a++) begin
      v = next_rand();
      wr_reg(a[3:0], v);
      rd_reg(a[3:0], v);
    end
    // live counters, still zero since nothing has run, replace the limits
    wr_reg(tsc_pkg::CSR_ADDR, 16'h0100);
    for (int a = 3; a < 6; a++) rd_reg(a[3:0], 16'h0000);
    do_reset();
    wr_reg(tsc_pkg::IT_LIM_ADDR, 16'h0300);
    wr_reg(tsc_pkg::CMD_ADDR, {tsc_pkg::OP_TRIG, 12'h000});
    wr_reg(tsc_pkg::CSR_ADDR, 16'h0080);
    see_trig(1'b0, 40);
    idle <= 1'b1;
    wr_reg(tsc_pkg::CSR_ADDR, 16'hA080);
    see_trig(1'b0, 40);
    idle <= 1'b0;
    see_trig(1'b1, 60);
    repeat (10) @(negedge sys_clk);
    chk("pulse width", 16'h0003, width);
    wr_reg(tsc_pkg::CSR_ADDR, 16'h0000);
    see_irq(1'b0);
    wr_reg(tsc_pkg::IRQ_MASK_ADDR, 16'h0002);
    see_irq(1'b1);
    wr_reg(tsc_pkg::IRQ_STAT_ADDR, 16'h0002);
    see_irq(1'b0);
    // soft trigger gate in toggle mode
    do_reset();
    wr_reg(tsc_pkg::CMD_ADDR, {tsc_pkg::OP_CTRL_SWT, 12'h000});
    wr_reg(tsc_pkg::CMD_ADDR, {tsc_pkg::OP_TRIG, 12'h000});
    wr_reg(tsc_pkg::CSR_ADDR, 16'h9080);
    see_trig(1'b0, 40);
    wr_reg(tsc_pkg::CSR_ADDR, 16'h9080);
    see_trig(1'b0, 20);
    v = edges;
    wr_reg(tsc_pkg::CSR_ADDR, 16'h9480);
    see_trig(1'b1, 40);
    rd_reg(tsc_pkg::CSR_ADDR, 16'h9080);
    @(negedge sys_clk);
    chk("toggle edges", v + 16'h0001, edges);
    // A second soft trigger lets the next emit invert the level back
    wr_reg(tsc_pkg::CSR_ADDR, 16'h9480);
    repeat (30) @(negedge sys_clk);
    chk("toggle level", 16'h0000, {15'h0000, trig});
    chk("toggle edges", v + 16'h0002, edges);
    // stuck wait raises the timeout flag and stops the run
    do_reset();
    wait_level <= 1'b0;
    wr_reg(tsc_pkg::CMD_ADDR, {tsc_pkg::OP_WAIT_HI, 12'h000});
    wr_reg(tsc_pkg::CSR_ADDR, 16'h8080);
    repeat (300) @(posedge sys_clk);
    rd_reg(tsc_pkg::CSR_ADDR, 16'h8040);
    wr_reg(tsc_pkg::IRQ_MASK_ADDR, 16'h0001);
    see_irq(1'b1);
    do_reset();
    rd_reg(tsc_pkg::CSR_ADDR, tsc_pkg::CSR_RESET);
    // single step parks after each command until a soft trigger
    wr_reg(tsc_pkg::CMD_ADDR, {tsc_pkg::OP_TRIG, 12'h000});
    wr_reg(tsc_pkg::CMD_ADDR, {tsc_pkg::OP_TRIG, 12'h000});
    wr_reg(tsc_pkg::CSR_ADDR, 16'h9280);
    see_trig(1'b1, 40);
    repeat (20) @(negedge sys_clk);
    chk("step hold", 16'h0001, {15'h0000, trig});
    wr_reg(tsc_pkg::CSR_ADDR, 16'h9680);
    repeat (20) @(negedge sys_clk);
    chk("step advance", 16'h0000, {15'h0000, trig});
    do_reset();
    // wait-for-low passes on a high pin once polarity is inverted
    // with idle-stop clear the sequencer keeps running in Idle
    idle <= 1'b1;
    wait_level <= 1'b1;
    wr_reg(tsc_pkg::CMD_ADDR, {tsc_pkg::OP_WAIT_LO, 12'h000});
    wr_reg(tsc_pkg::CMD_ADDR, {tsc_pkg::OP_TRIG, 12'h000});
    wr_reg(tsc_pkg::CSR_ADDR, 16'h8081);
    see_trig(1'b1, 40);
    repeat (4) @(posedge sys_clk);
    results();
  end
endmodule // testbench
`default_nettype wire
